//--- design/uart_enh_flow.v
// enhanced feature and flow control logic of one serial channel
// assumes fifo level, trigger, receive stream and transmitter on SYS_CLK;
// only the clear-to-send pin is asynchronous
`timescale 1ns/100ps
`include "uart_enh_regs.vh"

module uart_enh_flow #(
  parameter LW = 5
) (
  // clock and reset
  input  wire          SYS_CLK,
  input  wire          SYS_RST,
  // register port
  input  wire [3:0]    REG_ADDR,
  input  wire [7:0]    REG_WDATA,
  input  wire          REG_WR,
  input  wire          REG_RD,
  output reg  [7:0]    REG_RDATA,
  // line pins
  input  wire          CTS_N,
  output reg           RTS_N,
  // receive fifo state
  input  wire [LW-1:0] RX_LEVEL,
  input  wire [LW-1:0] RX_TRIGGER,
  // receive character stream
  input  wire          RX_VALID,
  input  wire [7:0]    RX_DATA,
  output reg           RX_STORE_VALID,
  output reg  [7:0]    RX_STORE_DATA,
  // transmitter side
  input  wire          TX_BUSY,
  output reg           TX_HOLD,
  output reg           TX_INJ_VALID,
  output reg  [7:0]    TX_INJ_DATA,
  input  wire          TX_INJ_TAKE,
  // interrupt
  output reg           IRQ
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  reg  [7:0]    scratch_r;
  reg  [7:0]    efc_r;
  reg  [7:0]    resume1_r;
  reg  [7:0]    resume2_r;
  reg  [7:0]    stop1_r;
  reg  [7:0]    stop2_r;
  reg  [7:0]    int_en_r;
  reg  [7:0]    fifo_ctl_r;
  reg  [7:0]    modem_r;
  reg  [7:0]    int_stat_r;
  reg  [7:0]    int_stat_nxt;
  reg  [7:0]    int_mask_r;
  reg           cts_m_r;
  reg           cts_s_r;
  reg           rts_hold_r;
  reg           over_trig_r;
  reg           peer_stop_r;
  reg           peer_stop_nxt;
  reg  [1:0]    pend_r;
  reg  [1:0]    pend_nxt;
  reg           store_nxt;
  reg           sent_stop_r;
  reg  [1:0]    inj_st_r;
  reg           inj_stop_r;
  reg           ev_stop;
  reg           ev_resume;
  reg           ev_special;
  reg  [7:0]    rd_nxt;

  // injector states
  localparam INJ_IDLE  = 2'h0;
  localparam INJ_FIRST = 2'h1;
  localparam INJ_SECND = 2'h2;

  // pending pair states
  localparam PEND_NONE = 2'h0;
  localparam PEND_STOP = 2'h1;
  localparam PEND_RES  = 2'h2;

  wire          enh_en   = efc_r[`EFC_ENH_EN];
  wire          auto_rts = efc_r[`EFC_AUTO_RTS];
  wire          auto_cts = efc_r[`EFC_AUTO_CTS];
  wire [1:0]    tx_mode  = efc_r[3:2];
  wire [1:0]    rx_mode  = efc_r[1:0];
  wire          wr_hit   = REG_WR;
  wire          rd_stat  = REG_RD & (REG_ADDR == `OFS_INT_STAT);

  // widened level compares
  wire [LW:0]   lvl      = {1'b0, RX_LEVEL};
  wire [LW:0]   trg      = {1'b0, RX_TRIGGER};
  wire          at_trig  = lvl >= trg;
  wire          above    = lvl >= trg + {{LW{1'b0}}, 1'b1};
  wire          below_lo = lvl + {{LW{1'b0}}, 1'b1} < trg;

  // merge of a guarded register write
  function [7:0] guard_wr;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] guard;
    input       en;
    begin
      if (en) begin
        guard_wr = new_v;
      end else begin
        guard_wr = (old_v & guard) | (new_v & ~guard);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      scratch_r  <= `RST_BYTE;
      efc_r      <= `RST_BYTE;
      resume1_r  <= `RST_BYTE;
      resume2_r  <= `RST_BYTE;
      stop1_r    <= `RST_BYTE;
      stop2_r    <= `RST_BYTE;
      int_en_r   <= `RST_BYTE;
      fifo_ctl_r <= `RST_BYTE;
      modem_r    <= `RST_BYTE;
      int_mask_r <= `RST_BYTE;
    end else if (wr_hit) begin
      case (REG_ADDR)
        `OFS_SCRATCH:   scratch_r  <= REG_WDATA;
        `OFS_EFC:       efc_r      <= REG_WDATA;
        `OFS_RESUME1:   resume1_r  <= REG_WDATA;
        `OFS_RESUME2:   resume2_r  <= REG_WDATA;
        `OFS_STOP1:     stop1_r    <= REG_WDATA;
        `OFS_STOP2:     stop2_r    <= REG_WDATA;
        `OFS_INT_EN:
          int_en_r <= guard_wr(int_en_r, REG_WDATA,
                               `INT_EN_GUARD, enh_en);
        `OFS_FIFO_CTL:
          fifo_ctl_r <= guard_wr(fifo_ctl_r, REG_WDATA,
                                 `FIFO_CTL_GUARD, enh_en);
        `OFS_MODEM_CTL:
          modem_r <= guard_wr(modem_r, REG_WDATA,
                              `MODEM_GUARD, enh_en);
        `OFS_INT_MASK:  int_mask_r <= REG_WDATA;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // clear-to-send synchroniser and transmit hold
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cts_m_r <= 1'b0;
      cts_s_r <= 1'b0;
      TX_HOLD <= 1'b0;
    end else begin
      cts_m_r <= CTS_N;
      cts_s_r <= cts_m_r;
      // hold changes only between characters
      if (!TX_BUSY) begin
        TX_HOLD <= (auto_cts & cts_s_r) | peer_stop_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // request-to-send control
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rts_hold_r  <= 1'b0;
      over_trig_r <= 1'b0;
      RTS_N       <= 1'b1;
    end else begin
      over_trig_r <= at_trig;
      if (!auto_rts) begin
        rts_hold_r <= 1'b0;
        RTS_N      <= ~modem_r[`MODEM_RTS_BIT];
      end else begin
        if (above) begin
          rts_hold_r <= 1'b1;
        end else if (below_lo) begin
          rts_hold_r <= 1'b0;
        end
        RTS_N <= rts_hold_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive comparison
  // ----------------------------------------------------------------
  always @* begin
    peer_stop_nxt = peer_stop_r;
    pend_nxt      = pend_r;
    store_nxt     = RX_VALID;
    ev_stop       = 1'b0;
    ev_resume     = 1'b0;
    ev_special    = 1'b0;
    if (RX_VALID) begin
      if (efc_r[`EFC_SPECIAL] && RX_DATA == stop2_r) begin
        ev_special = 1'b1;
      end
      case (rx_mode)
        2'b10, 2'b01: begin
          pend_nxt = PEND_NONE;
          if (RX_DATA == (rx_mode[1] ? stop1_r : stop2_r)) begin
            peer_stop_nxt = 1'b1;
            ev_stop       = 1'b1;
            store_nxt     = 1'b0;
          end else if (RX_DATA == (rx_mode[1] ? resume1_r : resume2_r)) begin
            peer_stop_nxt = 1'b0;
            ev_resume     = 1'b1;
            store_nxt     = 1'b0;
          end
        end
        2'b11: begin
          pend_nxt = PEND_NONE;
          if (pend_r == PEND_STOP && RX_DATA == stop2_r) begin
            peer_stop_nxt = 1'b1;
            ev_stop       = 1'b1;
            store_nxt     = 1'b0;
          end else if (pend_r == PEND_RES && RX_DATA == resume2_r) begin
            peer_stop_nxt = 1'b0;
            ev_resume     = 1'b1;
            store_nxt     = 1'b0;
          end else if (RX_DATA == stop1_r) begin
            pend_nxt  = PEND_STOP;
            store_nxt = 1'b0;
          end else if (RX_DATA == resume1_r) begin
            pend_nxt  = PEND_RES;
            store_nxt = 1'b0;
          end
        end
        default: begin
          peer_stop_nxt = 1'b0;
          pend_nxt      = PEND_NONE;
        end
      endcase
    end else if (rx_mode == 2'b00) begin
      peer_stop_nxt = 1'b0;
      pend_nxt      = PEND_NONE;
    end
  end

  // registered receive outputs
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      peer_stop_r    <= 1'b0;
      pend_r         <= PEND_NONE;
      RX_STORE_VALID <= 1'b0;
      RX_STORE_DATA  <= 8'h00;
    end else begin
      peer_stop_r    <= peer_stop_nxt;
      pend_r         <= pend_nxt;
      RX_STORE_VALID <= store_nxt;
      RX_STORE_DATA  <= RX_DATA;
    end
  end

  // ----------------------------------------------------------------
  // flow character injector
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      inj_st_r     <= INJ_IDLE;
      inj_stop_r   <= 1'b0;
      sent_stop_r  <= 1'b0;
      TX_INJ_VALID <= 1'b0;
      TX_INJ_DATA  <= 8'h00;
    end else begin
      case (inj_st_r)
        INJ_IDLE: begin
          if (tx_mode == 2'b00) begin
            sent_stop_r <= 1'b0;
          end else if (at_trig != sent_stop_r) begin
            sent_stop_r  <= at_trig;
            inj_stop_r   <= at_trig;
            inj_st_r     <= INJ_FIRST;
            TX_INJ_VALID <= 1'b1;
            // first character of the chosen pair, lsb first on line
            if (tx_mode[1]) begin
              TX_INJ_DATA <= at_trig ? stop1_r : resume1_r;
            end else begin
              TX_INJ_DATA <= at_trig ? stop2_r : resume2_r;
            end
          end
        end
        INJ_FIRST: begin
          if (TX_INJ_TAKE) begin
            if (tx_mode == 2'b11) begin
              inj_st_r    <= INJ_SECND;
              TX_INJ_DATA <= inj_stop_r ? stop2_r : resume2_r;
            end else begin
              inj_st_r     <= INJ_IDLE;
              TX_INJ_VALID <= 1'b0;
            end
          end
        end
        INJ_SECND: begin
          if (TX_INJ_TAKE) begin
            inj_st_r     <= INJ_IDLE;
            TX_INJ_VALID <= 1'b0;
          end
        end
        default: begin
          inj_st_r     <= INJ_IDLE;
          TX_INJ_VALID <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and output
  // ----------------------------------------------------------------
  always @* begin
    int_stat_nxt = int_stat_r;
    if (rd_stat) begin
      int_stat_nxt = 8'h00;
    end
    if (wr_hit && REG_ADDR == `OFS_INT_STAT && enh_en) begin
      int_stat_nxt = int_stat_nxt | (REG_WDATA & `INT_ST_GUARD);
    end
    // events win over the read clear
    if (auto_rts && at_trig && !over_trig_r) begin
      int_stat_nxt[`IST_TRIGGER] = 1'b1;
    end
    if (ev_stop) begin
      int_stat_nxt[`IST_STOP_RX] = 1'b1;
    end
    if (ev_resume) begin
      int_stat_nxt[`IST_RESUME_RX] = 1'b1;
    end
    if (ev_special) begin
      int_stat_nxt[`IST_SPECIAL] = 1'b1;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      int_stat_r <= `RST_BYTE;
      IRQ        <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      IRQ        <= |(int_stat_nxt & int_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always @* begin
    rd_nxt = 8'h00;
    case (REG_ADDR)
      `OFS_SCRATCH:   rd_nxt = scratch_r;
      `OFS_EFC:       rd_nxt = {efc_r[7], auto_rts & rts_hold_r,
                                efc_r[5:0]};
      `OFS_RESUME1:   rd_nxt = resume1_r;
      `OFS_RESUME2:   rd_nxt = resume2_r;
      `OFS_STOP1:     rd_nxt = stop1_r;
      `OFS_STOP2:     rd_nxt = stop2_r;
      `OFS_INT_EN:    rd_nxt = int_en_r;
      `OFS_FIFO_CTL:  rd_nxt = fifo_ctl_r;
      `OFS_MODEM_CTL: rd_nxt = modem_r;
      `OFS_INT_STAT:  rd_nxt = int_stat_r;
      `OFS_INT_MASK:  rd_nxt = int_mask_r;
      `OFS_FLOW_STAT: rd_nxt = {4'h0, cts_s_r, rts_hold_r,
                                peer_stop_r, TX_HOLD};
      default:        rd_nxt = 8'h00;
    endcase
  end

  // read data stand one cycle after the strobe
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rd_nxt;
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

endmodule

//--- design/uart_enh_regs.vh
// register offsets, field positions and reset values of the enhanced block
// assumes a 4-bit register address and 8-bit register data
`ifndef UART_ENH_REGS_VH
`define UART_ENH_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_SCRATCH    4'h0
`define OFS_EFC        4'h1
`define OFS_RESUME1    4'h2
`define OFS_RESUME2    4'h3
`define OFS_STOP1      4'h4
`define OFS_STOP2      4'h5
`define OFS_INT_EN     4'h6
`define OFS_FIFO_CTL   4'h7
`define OFS_MODEM_CTL  4'h8
`define OFS_INT_STAT   4'h9
`define OFS_INT_MASK   4'ha
`define OFS_FLOW_STAT  4'hb

// ----------------------------------------------------------------
// enhanced feature control fields
// ----------------------------------------------------------------
`define EFC_AUTO_CTS   7
`define EFC_AUTO_RTS   6
`define EFC_SPECIAL    5
`define EFC_ENH_EN     4

// bits guarded by the enhanced enable
`define INT_EN_GUARD   8'hf0
`define FIFO_CTL_GUARD 8'h30
`define MODEM_GUARD    8'he0
`define INT_ST_GUARD   8'h30

// modem control bit driving the request-to-send line
`define MODEM_RTS_BIT  1

// ----------------------------------------------------------------
// interrupt status fields
// ----------------------------------------------------------------
`define IST_TRIGGER    0
`define IST_STOP_RX    1
`define IST_RESUME_RX  2
`define IST_SPECIAL    4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BYTE       8'h00

`endif

//--- verification/line_peer.sv
// transmitter and line model on the far side of the flow block
// assumes one clock; a character occupies cl cycles on the line
`timescale 1ns/100ps

module line_peer #(
  parameter CL = 12
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       go,
  input  wire       hold,
  input  wire       inj_v,
  input  wire [7:0] inj_d,
  output reg        busy,
  output reg        take
);
  integer   cnt;
  integer   n_sent;
  reg [7:0] sent [0:15];

  // flow chars go first, data chars only while not held
  always @(posedge clk) begin
    take <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
      cnt <= 0;
      n_sent <= 0;
    end else if (busy) begin
      cnt <= cnt - 1;
      if (cnt == 1)
        busy <= 1'b0;
    end else if (inj_v) begin
      take <= 1'b1;
      busy <= 1'b1;
      cnt <= CL;
      sent[n_sent] <= inj_d;
      n_sent <= n_sent + 1;
    end else if (go && !hold) begin
      busy <= 1'b1;
      cnt <= CL;
    end
  end
endmodule

//--- verification/uart_enh_flow_chk.sv
// concurrent checks on the ports of the enhanced flow block
// assumes the register header is on the include path
`timescale 1ns/100ps
`include "uart_enh_regs.vh"

module uart_enh_flow_chk #(
  parameter LW = 5
) (
  // clock and reset
  input wire          SYS_CLK,
  input wire          SYS_RST,
  // register port
  input wire [3:0]    REG_ADDR,
  input wire [7:0]    REG_WDATA,
  input wire          REG_WR,
  input wire          REG_RD,
  input wire [7:0]    REG_RDATA,
  // line pins
  input wire          CTS_N,
  input wire          RTS_N,
  // receive side
  input wire [LW-1:0] RX_LEVEL,
  input wire [LW-1:0] RX_TRIGGER,
  input wire          RX_VALID,
  input wire [7:0]    RX_DATA,
  input wire          RX_STORE_VALID,
  input wire [7:0]    RX_STORE_DATA,
  // transmit side
  input wire          TX_BUSY,
  input wire          TX_HOLD,
  input wire          TX_INJ_VALID,
  input wire [7:0]    TX_INJ_DATA,
  input wire          TX_INJ_TAKE
);
  reg [7:0] efc_r;
  reg       mdm_r;

  // shadow of feature control and the software rts bit
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      efc_r <= 8'h00;
      mdm_r <= 1'b0;
    end else begin
      if (REG_WR && REG_ADDR == `OFS_EFC)
        efc_r <= REG_WDATA;
      if (REG_WR && REG_ADDR == `OFS_MODEM_CTL)
        mdm_r <= REG_WDATA[`MODEM_RTS_BIT];
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  a_rdata_idle:
    assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside its slot");
  a_store_echo:
    assert property (RX_STORE_VALID |-> $past(RX_VALID)
      && RX_STORE_DATA == $past(RX_DATA)) else $error("bad store");
  a_rts_rise:
    assert property ((efc_r[`EFC_AUTO_RTS] && RX_LEVEL > RX_TRIGGER) [*3]
      |-> RTS_N) else $error("rts not raised above trigger");
  a_rts_fall:
    assert property ((efc_r[`EFC_AUTO_RTS] && RX_LEVEL + 1 < RX_TRIGGER)
      [*3] |-> !RTS_N) else $error("rts not released below trigger");
  a_rts_soft:
    assert property (!$past(efc_r[`EFC_AUTO_RTS]) |-> RTS_N == !$past(mdm_r))
    else $error("software rts mismatch");
  a_hold_between:
    assert property ($changed(TX_HOLD) |-> !$past(TX_BUSY))
    else $error("hold changed inside a character");
  a_cts_stop:
    assert property ((efc_r[`EFC_AUTO_CTS] && CTS_N && !TX_BUSY) [*6]
      |-> TX_HOLD) else $error("cts did not stop transmitter");
  a_inj_stand:
    assert property (TX_INJ_VALID && !TX_INJ_TAKE |=> TX_INJ_VALID
      && $stable(TX_INJ_DATA)) else $error("flow char dropped");
endmodule

bind uart_enh_flow uart_enh_flow_chk #(.LW(LW)) i_chk (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .CTS_N(CTS_N), .RTS_N(RTS_N),
  .RX_LEVEL(RX_LEVEL), .RX_TRIGGER(RX_TRIGGER), .RX_VALID(RX_VALID),
  .RX_DATA(RX_DATA), .RX_STORE_VALID(RX_STORE_VALID),
  .RX_STORE_DATA(RX_STORE_DATA), .TX_BUSY(TX_BUSY), .TX_HOLD(TX_HOLD),
  .TX_INJ_VALID(TX_INJ_VALID), .TX_INJ_DATA(TX_INJ_DATA),
  .TX_INJ_TAKE(TX_INJ_TAKE));

//--- verification/uart_enh_flow_test.sv
// self-checking bench for the enhanced flow block
// assumes design, header and line model compiled alongside
`timescale 1ns/100ps
`include "uart_enh_regs.vh"

module uart_enh_flow_test;
  logic       clk, rst, we, re, cts_n, rxv, go, rts_n, stv;
  logic       busy, hold, injv, take, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rxd, sdat, injd;
  logic [4:0] lvl, trig;
  logic [7:0] e [0:3];
  integer     n_errors = 0, check_count = 0, cyc = 0, i, j, k, n0;

  uart_enh_flow #(.LW(5)) i_dut (
    .SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(we), .REG_RD(re), .REG_RDATA(rdata), .CTS_N(cts_n),
    .RTS_N(rts_n), .RX_LEVEL(lvl), .RX_TRIGGER(trig), .RX_VALID(rxv),
    .RX_DATA(rxd), .RX_STORE_VALID(stv), .RX_STORE_DATA(sdat),
    .TX_BUSY(busy), .TX_HOLD(hold), .TX_INJ_VALID(injv),
    .TX_INJ_DATA(injd), .TX_INJ_TAKE(take), .IRQ(irq));
  line_peer #(.CL(12)) i_peer (.clk(clk), .rst(rst), .go(go),
    .hold(hold), .inj_v(injv), .inj_d(injd), .busy(busy), .take(take));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // -------------------------------------------------------------
  // bus, line and compare helpers
  // -------------------------------------------------------------
  task chk(input string n, input logic [7:0] s, x);
    check_count++;
    if (s !== x) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task pause(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk);
    we <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 0;
  endtask
  task rc(input [3:0] a, input [7:0] x, input string n);
    @(posedge clk);
    re <= 1;
    addr <= a;
    @(posedge clk);
    re <= 0;
    #1 chk(n, rdata, x);
  endtask
  task rx(input [7:0] d, input x, input string n);
    @(posedge clk);
    rxv <= 1;
    rxd <= d;
    @(posedge clk);
    rxv <= 0;
    #1 chk(n, stv, x);
    if (x) chk(n, sdat, d);
  endtask
  task lv(input [4:0] l, input x);
    @(posedge clk);
    lvl <= l;
    pause(4);
    chk("rts", rts_n, x);
  endtask
  task wait_sent(input integer n);
    integer c;
    c = 0;
    while (i_peer.n_sent < n && c < 100) begin
      @(posedge clk);
      c++;
    end
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task t_regs;
    chk("rts", rts_n, 1);
    rc(`OFS_EFC, 8'h00, "efc");
    wr(`OFS_SCRATCH, 8'ha5);
    wr(4'hc, 8'hff);
    rc(`OFS_SCRATCH, 8'ha5, "scratch");
    rc(4'hc, 8'h00, "unmapped");
    wr(`OFS_INT_EN, 8'hff);
    rc(`OFS_INT_EN, 8'h0f, "ien locked");
    wr(`OFS_EFC, 8'h10);
    wr(`OFS_INT_EN, 8'hff);
    rc(`OFS_INT_EN, 8'hff, "ien open");
    wr(`OFS_EFC, 8'h00);
    wr(`OFS_INT_EN, 8'h00);
    rc(`OFS_INT_EN, 8'hf0, "ien latched");
    $display("test registers done");
  endtask
  task t_special;
    wr(`OFS_INT_MASK, 8'h10);
    wr(`OFS_EFC, 8'h20);
    rx(8'h14, 1, "special");
    pause(3);
    chk("irq", irq, 1);
    rc(`OFS_INT_STAT, 8'h10, "status");
    rx(8'h28, 1, "mirror");
    pause(3);
    chk("irq", irq, 0);
    wr(`OFS_INT_MASK, 8'h00);
    rx(8'h14, 1, "special");
    pause(3);
    chk("irq masked", irq, 0);
    rc(`OFS_INT_STAT, 8'h10, "status");
    wr(`OFS_EFC, 8'h00);
    $display("test special done");
  endtask
  task t_rts;
    trig <= 5'd4;
    wr(`OFS_INT_MASK, 8'h01);
    wr(`OFS_EFC, 8'h40);
    lv(5'd4, 0);
    chk("irq", irq, 1);
    rc(`OFS_INT_STAT, 8'h01, "status");
    lv(5'd5, 1);
    rc(`OFS_EFC, 8'h40, "efc flow");
    lv(5'd3, 1);
    lv(5'd2, 0);
    rc(`OFS_EFC, 8'h00, "efc flow");
    wr(`OFS_EFC, 8'h00);
    wr(`OFS_INT_MASK, 8'h00);
    lv(5'd9, 1);
    wr(`OFS_MODEM_CTL, 8'h02);
    pause(2);
    chk("soft rts", rts_n, 0);
    wr(`OFS_MODEM_CTL, 8'h00);
    lv(5'd0, 1);
    $display("test rts done");
  endtask
  task t_cts;
    wr(`OFS_EFC, 8'h80);
    go <= 1;
    pause(2);
    go <= 0;
    cts_n <= 1;
    pause(6);
    chk("hold in char", hold, 0);
    pause(12);
    chk("hold", hold, 1);
    cts_n <= 0;
    pause(6);
    chk("hold", hold, 0);
    wr(`OFS_EFC, 8'h00);
    $display("test cts done");
  endtask
  task t_rxflow;
    for (i = 0; i < 3; i++) begin
      wr(`OFS_EFC, i == 0 ? 8'h02 : i == 1 ? 8'h01 : 8'h03);
      if (i != 1) rx(8'h13, 0, "stop1");
      if (i != 0) rx(8'h14, 0, "stop2");
      pause(5);
      chk("hold", hold, 1);
      rx(8'h55, 1, "data");
      if (i != 1) rx(8'h11, 0, "resume1");
      if (i != 0) rx(8'h12, 0, "resume2");
      pause(5);
      chk("hold", hold, 0);
    end
    wr(`OFS_EFC, 8'h00);
    $display("test rx flow done");
  endtask
  task t_txflow;
    for (i = 1; i < 4; i++) begin
      j = 0;
      if (i[1]) e[j++] = 8'h13;
      if (i[0]) e[j++] = 8'h14;
      if (i[1]) e[j++] = 8'h11;
      if (i[0]) e[j++] = 8'h12;
      n0 = i_peer.n_sent;
      wr(`OFS_EFC, {4'h0, i[1:0], 2'b00});
      lvl <= 5'd4;
      wait_sent(n0 + j / 2);
      lvl <= 5'd0;
      wait_sent(n0 + j);
      for (k = 0; k < j; k++) begin
        chk("flow char", i_peer.sent[n0 + k], e[k]);
      end
    end
    wr(`OFS_EFC, 8'h00);
    $display("test tx flow done");
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // run limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict;
    end
  end

  initial begin
    {rst, we, re, rxv, go, cts_n} = 6'b100000;
    {addr, wdata, rxd, lvl, trig} = '0;
    repeat (16) @(posedge clk);
    rst <= 0;
    t_regs;
    wr(`OFS_RESUME1, 8'h11);
    wr(`OFS_RESUME2, 8'h12);
    wr(`OFS_STOP1, 8'h13);
    wr(`OFS_STOP2, 8'h14);
    t_special;
    t_rts;
    t_cts;
    t_rxflow;
    t_txflow;
    give_verdict;
  end
endmodule
